/* File: design/frw_pkg.sv */
package frw_pkg;
   // Register offsets on the plain port
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_FIRST = 4'h1;
   localparam logic [3:0] ADDR_LAST = 4'h2;
   localparam logic [3:0] ADDR_SIZE = 4'h3;
   localparam logic [3:0] ADDR_DATA0 = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   localparam logic [3:0] ADDR_RESULT = 4'hD;
   localparam logic [3:0] ADDR_TIMING = 4'hE;
   localparam logic [3:0] ADDR_DELAY = 4'hF;
   // Control field positions
   localparam int CTRL_PROG_SEL_BIT = 0;
   localparam int CTRL_ERASE_BIT = 1;
   localparam int CTRL_HV_EN_BIT = 3;
   localparam int CTRL_RED_ROW_BIT = 4;
   localparam int CTRL_RERASE_BIT = 5;
   // Erase size field in bits 6:5 of the size byte
   localparam int SIZE_LSB = 5;
   localparam logic [1:0] SIZE_FULL = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_EIGHT = 2'h2;
   localparam logic [1:0] SIZE_ROW = 2'h3;
   // Array geometry
   localparam int ROW_BYTES = 8;
   localparam int ROW_SHIFT = 3;
   localparam int ADDR_W = 16;
   localparam int CYCLE_BIT = 7;
   localparam logic [15:0] ARRAY_BASE = 16'h7800;
   localparam logic [15:0] ARRAY_SPAN = 16'h0800;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_ADDR = 16'h0000;
   // Array operation per step, one cycle at 20 MHz
   localparam int CLK_MHZ = 20;
   localparam int STEP_NS = 50;
   localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [6:0] {
      FRW_IDLE = 7'b000_0001,
      FRW_SCAN = 7'b000_0010,
      FRW_ERASE = 7'b000_0100,
      FRW_PROG = 7'b000_1000,
      FRW_VERIFY = 7'b001_0000,
      FRW_DONE = 7'b010_0000,
      FRW_RERASE = 7'b100_0000
   } frw_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } frw_bus_s;

   typedef struct packed {
      logic req;
      logic we;
      logic er;
      logic [15:0] addr;
      logic [15:0] len;
      logic [7:0] wdata;
   } frw_arr_s;
endpackage : frw_pkg

/* File: design/frw_pump.sv */
`timescale 1ns/1ps
module frw_pump
   import frw_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic hv_req,
   input wire logic low_power,
   output logic pump_on
);
   typedef struct packed {
      logic on;
   } frw_pump_s;
   frw_pump_s st_q, st_d;

   // Pump follows the high-voltage request except in wait or stop
   always_comb begin
      st_d = st_q;
      st_d.on = hv_req & ~low_power;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pump_on = st_q.on;
endmodule : frw_pump

/* File: design/frw_array.sv */
`timescale 1ns/1ps
module frw_array
   import frw_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic pump_on,
   input wire logic standby,
   input wire frw_arr_s cmd,
   input wire logic [15:0] raddr,
   output logic [7:0] rdata
);
   localparam int DEPTH = 64;
   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [7:0] rd;
   } frw_array_s;
   frw_array_s st_q, st_d;

   function automatic logic [5:0] idx(input logic [15:0] a);
      idx = a[5:0];
   endfunction : idx

   // Small model array; writes and erases only with the pump running
   always_comb begin
      st_d = st_q;
      if (!standby) begin
         st_d.rd = st_q.mem[idx(raddr)];
      end
      if (cmd.req && pump_on) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (cmd.er && (16'(i) >= (cmd.addr & 16'(DEPTH - 1)))
                && (16'(i) < (cmd.addr & 16'(DEPTH - 1)) + cmd.len)) begin
               st_d.mem[i] = 8'hFF;
            end
         end
         if (cmd.we) begin
            // Programming only clears bits, as flash does
            st_d.mem[idx(cmd.addr)] = st_q.mem[idx(cmd.addr)] & cmd.wdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rd;
endmodule : frw_array

/* File: design/frw_top.sv */
// Operation
// - range erase clears block sized by control
// - range erase returns caller's address unchanged
// - always take eight data bytes
// - row count is (last - first) / 8 + 1
// - write all rows before any twice
// - first byte bit 7 is cycling marker
// - pick first row differing from first
// - erase row, program with inverted marker
// - carry on success, interrupt mask set
// - wait in read mode changes nothing
// - wait disables the charge pump
// - program or erase bits hold through
// - stop in read mode enters standby
// - stop disables the charge pump
`timescale 1ns/1ps
module frw_top
   import frw_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire frw_bus_s bus,
   input wire logic cpu_wait,
   input wire logic cpu_stop,
   output logic [15:0] rdata,
   output logic program_select,
   output logic erase_sel,
   output logic high_voltage_enable,
   output logic array_standby,
   output logic carry_flag,
   output logic int_mask,
   output logic busy
);
   typedef struct packed {
      frw_state_e state;
      logic prog_sel;
      logic era;
      logic hv_en;
      logic [15:0] first;
      logic [15:0] last_address_param;
      logic [15:0] hx;
      logic [7:0] erase_size_control;
      // Timing values are held for software only; every step here is one cycle
      logic [7:0] pulse_limit;
      logic [7:0] bus_speed_param;
      logic [15:0] erase_delay_param;
      logic [7:0][7:0] data;
      logic [15:0] row;
      logic [15:0] rows_left;
      logic [2:0] byte_i;
      logic ref_mark;
      logic mark;
      logic rd_wait;
      logic carry;
      logic imask;
      logic busy;
      logic standby;
      logic [15:0] rdata;
   } frw_top_s;
   frw_top_s st_q, st_d;

   frw_arr_s arr_cmd;
   logic [15:0] arr_raddr;
   logic [7:0] arr_rdata;
   logic pump_on;
   logic low_power;
   logic hv_req;

   // Block length in bytes for the erase size code
   function automatic logic [15:0] erase_len(input logic [1:0] code);
      case (code)
         SIZE_FULL: erase_len = ARRAY_SPAN;
         SIZE_HALF: erase_len = ARRAY_SPAN >> 1;
         SIZE_EIGHT: erase_len = 16'(ROW_BYTES * 8);
         SIZE_ROW: erase_len = 16'(ROW_BYTES);
         default: erase_len = 16'(ROW_BYTES);
      endcase
   endfunction : erase_len

   // Start of the block that holds an address, aligned to its size
   function automatic logic [15:0] erase_base(input logic [15:0] a, input logic [1:0] code);
      erase_base = ARRAY_BASE + ((a - ARRAY_BASE) & ~(erase_len(code) - 16'h0001));
   endfunction : erase_base

   assign low_power = cpu_wait | cpu_stop;
   assign hv_req = st_q.hv_en & (st_q.prog_sel | st_q.era);

   frw_pump u_pump (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .hv_req(hv_req),
      .low_power(low_power),
      .pump_on(pump_on)
   );

   frw_array u_array (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .pump_on(pump_on),
      .standby(st_q.standby),
      .cmd(arr_cmd),
      .raddr(arr_raddr),
      .rdata(arr_rdata)
   );

   // Array command decode from the current state
   always_comb begin
      arr_cmd = '0;
      arr_raddr = st_q.row;
      case (st_q.state)
         FRW_ERASE: begin
            arr_cmd.req = 1'b1;
            arr_cmd.er = 1'b1;
            arr_cmd.addr = st_q.row;
            arr_cmd.len = 16'(ROW_BYTES);
         end
         FRW_RERASE: begin
            arr_cmd.req = 1'b1;
            arr_cmd.er = 1'b1;
            arr_cmd.addr = erase_base(st_q.hx, st_q.erase_size_control[SIZE_LSB +: 2]);
            arr_cmd.len = erase_len(st_q.erase_size_control[SIZE_LSB +: 2]);
         end
         FRW_PROG: begin
            arr_cmd.req = 1'b1;
            arr_cmd.we = 1'b1;
            arr_cmd.addr = st_q.row + 16'(st_q.byte_i);
            arr_cmd.wdata = st_q.data[st_q.byte_i];
            if (st_q.byte_i == 3'h0) begin
               arr_cmd.wdata[CYCLE_BIT] = ~st_q.mark;
            end
         end
         FRW_VERIFY: begin
            arr_raddr = st_q.row + 16'(st_q.byte_i);
         end
         default: begin
            arr_raddr = st_q.row;
         end
      endcase
   end

   // Sequencer and register port
   always_comb begin
      logic [7:0] want;
      want = st_q.data[st_q.byte_i];
      st_d = st_q;
      st_d.rdata = '0;
      st_d.standby = cpu_stop & ~hv_req;
      // wait in read mode no change
      if (bus.wr && st_q.state == FRW_IDLE) begin
         case (bus.addr)
            ADDR_CTRL: begin
               st_d.prog_sel = bus.wdata[CTRL_PROG_SEL_BIT];
               st_d.era = bus.wdata[CTRL_ERASE_BIT];
               st_d.hv_en = bus.wdata[CTRL_HV_EN_BIT];
               if (bus.wdata[CTRL_RED_ROW_BIT]) begin
                  st_d.rows_left = (st_q.last_address_param - st_q.first) >> ROW_SHIFT;
                  st_d.row = st_q.first;
                  st_d.rd_wait = 1'b1;
                  st_d.busy = 1'b1;
                  st_d.state = FRW_SCAN;
                  st_d.prog_sel = 1'b1;
               end else if (bus.wdata[CTRL_RERASE_BIT]) begin
                  st_d.busy = 1'b1;
                  st_d.era = 1'b1;
                  st_d.hv_en = 1'b1;
                  st_d.state = FRW_RERASE;
               end
            end
            ADDR_FIRST: begin
               st_d.first = bus.wdata;
               st_d.hx = bus.wdata;
            end
            ADDR_LAST: st_d.last_address_param = bus.wdata;
            ADDR_SIZE: st_d.erase_size_control = bus.wdata[7:0];
            ADDR_TIMING: begin
               st_d.pulse_limit = bus.wdata[7:0];
               st_d.bus_speed_param = bus.wdata[15:8];
            end
            ADDR_DELAY: st_d.erase_delay_param = bus.wdata;
            default: begin
               if (bus.addr >= ADDR_DATA0 && bus.addr < ADDR_DATA0 + 4'h8) begin
                  st_d.data[3'(bus.addr - ADDR_DATA0)] = bus.wdata[7:0];
               end
            end
         endcase
      end
      if (bus.rd) begin
         case (bus.addr)
            ADDR_CTRL: st_d.rdata = {12'h000, st_q.hv_en, 1'b0, st_q.era, st_q.prog_sel};
            ADDR_FIRST: st_d.rdata = st_q.hx;
            ADDR_LAST: st_d.rdata = st_q.last_address_param;
            ADDR_SIZE: st_d.rdata = {8'h00, st_q.erase_size_control};
            ADDR_STATUS: st_d.rdata = {13'h0000, st_q.standby, st_q.imask, st_q.busy};
            ADDR_RESULT: st_d.rdata = {15'h0000, st_q.carry};
            // Timing values read back as written
            ADDR_TIMING: st_d.rdata = {st_q.bus_speed_param, st_q.pulse_limit};
            ADDR_DELAY: st_d.rdata = st_q.erase_delay_param;
            default: begin
               if (bus.addr >= ADDR_DATA0 && bus.addr < ADDR_DATA0 + 4'h8) begin
                  st_d.rdata = {8'h00, st_q.data[3'(bus.addr - ADDR_DATA0)]};
               end
            end
         endcase
      end
      case (st_q.state)
         FRW_IDLE: begin
            st_d.busy = st_d.busy;
         end
         FRW_SCAN: begin
            // One cycle for the array read to land
            if (st_q.rd_wait) begin
               st_d.rd_wait = 1'b0;
            end else begin
               st_d.rd_wait = 1'b1;
               if (st_q.row == st_q.first) begin
                  st_d.ref_mark = arr_rdata[CYCLE_BIT];
                  st_d.mark = arr_rdata[CYCLE_BIT];
               end
               if (st_q.row != st_q.first && arr_rdata[CYCLE_BIT] != st_q.ref_mark) begin
                  st_d.mark = arr_rdata[CYCLE_BIT];
                  st_d.state = FRW_ERASE;
                  st_d.prog_sel = 1'b0;
                  st_d.era = 1'b1;
                  st_d.hv_en = 1'b1;
               end else if (st_q.rows_left == 16'h0000) begin
                  st_d.row = st_q.first;
                  st_d.mark = st_q.row == st_q.first ? arr_rdata[CYCLE_BIT] : st_q.ref_mark;
                  st_d.state = FRW_ERASE;
                  st_d.prog_sel = 1'b0;
                  st_d.era = 1'b1;
                  st_d.hv_en = 1'b1;
               end else begin
                  st_d.row = st_q.row + 16'(ROW_BYTES);
                  st_d.rows_left = st_q.rows_left - 16'h0001;
               end
            end
         end
         FRW_ERASE: begin
            if (pump_on) begin
               st_d.state = FRW_PROG;
               st_d.era = 1'b0;
               st_d.prog_sel = 1'b1;
               st_d.byte_i = 3'h0;
            end
         end
         FRW_RERASE: begin
            if (pump_on) begin
               st_d.era = 1'b0;
               st_d.hv_en = 1'b0;
               st_d.busy = 1'b0;
               st_d.imask = 1'b1;
               st_d.hx = st_q.hx;
               st_d.state = FRW_IDLE;
            end
         end
         FRW_PROG: begin
            if (pump_on) begin
               if (st_q.byte_i == 3'h7) begin
                  st_d.state = FRW_VERIFY;
                  st_d.prog_sel = 1'b0;
                  st_d.hv_en = 1'b0;
                  st_d.byte_i = 3'h0;
                  st_d.rd_wait = 1'b1;
                  st_d.carry = 1'b1;
               end else begin
                  st_d.byte_i = st_q.byte_i + 3'h1;
               end
            end
         end
         FRW_VERIFY: begin
            if (st_q.rd_wait) begin
               st_d.rd_wait = 1'b0;
            end else begin
               st_d.rd_wait = 1'b1;
               if (st_q.byte_i == 3'h0) begin
                  want[CYCLE_BIT] = ~st_q.mark;
               end
               if (arr_rdata != want) begin
                  st_d.carry = 1'b0;
               end
               if (st_q.byte_i == 3'h7) begin
                  st_d.state = FRW_DONE;
               end else begin
                  st_d.byte_i = st_q.byte_i + 3'h1;
               end
            end
         end
         FRW_DONE: begin
            st_d.imask = 1'b1;
            st_d.busy = 1'b0;
            st_d.data[0][CYCLE_BIT] = ~st_q.mark;
            st_d.state = FRW_IDLE;
         end
         default: st_d.state = FRW_IDLE;
      endcase
      // high voltage bits held in low power
      // Pump goes off at the same edge as the first hold; holding keeps the array out of read mode until reset
      if (low_power && hv_req) begin
         st_d.prog_sel = st_q.prog_sel;
         st_d.era = st_q.era;
         st_d.hv_en = st_q.hv_en;
      end
   end

   // reset returns array to read mode
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.state <= FRW_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from state flops
   assign rdata = st_q.rdata;
   assign program_select = st_q.prog_sel;
   assign erase_sel = st_q.era;
   assign high_voltage_enable = st_q.hv_en;
   assign array_standby = st_q.standby;
   assign carry_flag = st_q.carry;
   assign int_mask = st_q.imask;
   assign busy = st_q.busy;
endmodule : frw_top

/* File: bench/frw_top_chk.sv */
`timescale 1ns/1ps
module frw_top_chk
   import frw_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire frw_bus_s bus,
   input wire logic cpu_wait,
   input wire logic cpu_stop,
   input wire logic [15:0] rdata,
   input wire logic program_select,
   input wire logic erase_sel,
   input wire logic high_voltage_enable,
   input wire logic array_standby,
   input wire logic carry_flag,
   input wire logic int_mask,
   input wire logic busy
);
   logic first_q;

   // Marks the first edge after reset release
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   // Routine start, stop in read mode, low power with high voltage on
   sequence s_start;
      bus.wr && bus.addr == ADDR_CTRL && !busy
         && (bus.wdata[CTRL_RED_ROW_BIT] || bus.wdata[CTRL_RERASE_BIT]);
   endsequence
   sequence s_stop_read;
      (cpu_stop && !high_voltage_enable)[*2];
   endsequence
   sequence s_lp_hv;
      (program_select || erase_sel) && high_voltage_enable && (cpu_wait || cpu_stop);
   endsequence

   a_start_busy: assert property (s_start |=> busy)
      else $error("routine start did not raise busy");
   a_frozen_busy: assert property (
      (busy && high_voltage_enable && (cpu_wait || cpu_stop)) |=> busy)
      else $error("routine finished with the pump off");
   a_hv_hold_lp: assert property (
      s_lp_hv |=> $stable({program_select, erase_sel, high_voltage_enable}))
      else $error("high voltage bits changed in low power");
   a_stop_standby: assert property (s_stop_read |-> array_standby)
      else $error("stop in read mode without standby");
   a_standby_stop_only: assert property ((!cpu_stop)[*2] |-> !array_standby)
      else $error("standby without stop");
   a_hv_no_standby: assert property (high_voltage_enable[*2] |-> !array_standby)
      else $error("standby while high voltage held");
   a_reset_clears: assert property (first_q |-> !(program_select || erase_sel
      || high_voltage_enable || busy || carry_flag || int_mask))
      else $error("outputs not cleared by reset");
   a_done_mask: assert property ($fell(busy) |-> ##[0:1] int_mask)
      else $error("interrupt mask not set at completion");
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
      else $error("read data outside the answer cycle");
endmodule : frw_top_chk

/* File: bench/frw_cpu_model.sv */
`timescale 1ns/1ps
module frw_cpu_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic want_wait,
   input wire logic want_stop,
   input wire logic hv_on,
   output logic cpu_wait,
   output logic cpu_stop
);
   logic locked_q;

   // low power with high voltage only when told
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_wait <= 1'b0;
         cpu_stop <= 1'b0;
         locked_q <= 1'b0;
      end else if (!locked_q) begin
         cpu_wait <= want_wait;
         cpu_stop <= want_stop;
         locked_q <= (want_wait | want_stop) & hv_on; // No vector fetch possible
      end
   end
endmodule : frw_cpu_model

/* File: bench/frw_tb.sv */
`timescale 1ns/1ps
module tb;
   import frw_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   frw_bus_s bus = '0;
   logic want_wait = 1'b0;
   logic want_stop = 1'b0;
   logic cpu_wait, cpu_stop, program_select, erase_sel, high_voltage_enable;
   logic array_standby, carry_flag, int_mask, busy;
   logic [15:0] rdata, v;
   int fail_count = 0;
   int n_checks = 0;
   logic [4:0] mk = 5'h0C; // Marker after each call, two rows

   always #25 core_clk = ~core_clk;

   frw_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .bus(bus), .cpu_wait(cpu_wait),
      .cpu_stop(cpu_stop), .rdata(rdata), .program_select(program_select),
      .erase_sel(erase_sel), .high_voltage_enable(high_voltage_enable),
      .array_standby(array_standby), .carry_flag(carry_flag), .int_mask(int_mask),
      .busy(busy));
   frw_cpu_model i_cpu (.core_clk(core_clk), .reset_n(reset_n), .want_wait(want_wait),
      .want_stop(want_stop), .hv_on(high_voltage_enable), .cpu_wait(cpu_wait),
      .cpu_stop(cpu_stop));

   task automatic report_and_stop;
      if (fail_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask : chk

   // One-cycle strobes, launched just after an edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task automatic wait_idle;
      for (int i = 0; i < 2000; i++) begin
         @(posedge core_clk);
         #1;
         if (busy === 1'b0) return;
      end
      fail_count++;
      report_and_stop();
   endtask : wait_idle

   task automatic do_reset;
      @(posedge core_clk);
      reset_n <= 1'b0;
      want_wait <= 1'b0;
      want_stop <= 1'b0;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
   endtask : do_reset

   initial begin
      do_reset();
      // Two-row ring, each call leaves its marker in data byte 0
      wr(ADDR_FIRST, 16'h7800);
      wr(ADDR_LAST, 16'h7808);
      wr(ADDR_TIMING, 16'h080A);
      wr(ADDR_DELAY, 16'h1046);
      wr(ADDR_DATA0, 16'h0056);
      for (int i = 1; i < 8; i++) wr(ADDR_DATA0 + 4'(i), 16'(i));
      for (int k = 0; k < 5; k++) begin
         wr(ADDR_CTRL, 16'h0010);
         wait_idle();
         rd(ADDR_DATA0, v);
         chk("marker", {8'h00, mk[k], 7'h56}, v);
         rd(ADDR_RESULT, v);
         chk("carry", 16'h0001, v);
         rd(ADDR_STATUS, v);
         chk("status", 16'h0002, v);
      end
      rd(ADDR_TIMING, v);
      chk("timing", 16'h080A, v);
      rd(ADDR_DELAY, v);
      chk("delay", 16'h1046, v);
      // Every erase size; a write while busy must not move the address
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_SIZE, {9'h000, 2'(s), 5'h00});
         wr(ADDR_CTRL, 16'h0020);
         wr(ADDR_FIRST, 16'h7FF8);
         wait_idle();
         rd(ADDR_FIRST, v);
         chk("first", 16'h7800, v);
      end
      // Idle wait keeps read mode, idle stop gives standby
      want_wait <= 1'b1;
      repeat (20) @(posedge core_clk);
      rd(ADDR_STATUS, v);
      chk("wait status", 16'h0002, v);
      want_wait <= 1'b0;
      want_stop <= 1'b1;
      repeat (20) @(posedge core_clk);
      rd(ADDR_STATUS, v);
      chk("stop status", 16'h0006, v);
      want_stop <= 1'b0;
      repeat (4) @(posedge core_clk);
      // Program or erase with high voltage held through wait or stop
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_CTRL, i ? 16'h000A : 16'h0009);
         want_wait <= (i == 0);
         want_stop <= (i == 1);
         repeat (30) @(posedge core_clk);
         #1;
         chk("hv bits", i ? 16'h0005 : 16'h0003,
            {13'h0000, erase_sel, program_select, high_voltage_enable});
         chk("standby", 16'h0000, {15'h0000, array_standby});
         do_reset();
         #1;
         chk("reset bits", 16'h0000, {13'h0000, program_select, erase_sel,
            high_voltage_enable});
      end
      // Wait in mid-routine stalls it until reset
      wr(ADDR_CTRL, 16'h0010);
      repeat (3) @(posedge core_clk);
      want_wait <= 1'b1;
      repeat (100) @(posedge core_clk);
      #1;
      chk("stalled busy", 16'h0001, {15'h0000, busy});
      do_reset();
      #1;
      chk("reset busy", 16'h0000, {15'h0000, busy});
      report_and_stop();
   end
endmodule : tb

bind frw_top frw_top_chk i_chk (.core_clk(core_clk), .reset_n(reset_n), .bus(bus),
   .cpu_wait(cpu_wait), .cpu_stop(cpu_stop), .rdata(rdata),
   .program_select(program_select), .erase_sel(erase_sel),
   .high_voltage_enable(high_voltage_enable), .array_standby(array_standby),
   .carry_flag(carry_flag), .int_mask(int_mask), .busy(busy));
